// ===== inc/charge_pkg.sv
// constants and types shared by the charge source control block
package charge_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_LIMIT_CFG = 8'h06;
  localparam logic [7:0] ADDR_LIMIT_STAT = 8'h07;
  localparam logic [7:0] ADDR_EOC_MASK = 8'h80;
  localparam logic [7:0] ADDR_INT_STAT = 8'h40;
  localparam logic [7:0] ADDR_INT_CLR = 8'h41;
  localparam logic [7:0] ADDR_INT_EN = 8'h42;
  localparam logic [7:0] RST_LIMIT_CFG = 8'h11;
  localparam logic [7:0] RST_EOC_MASK = 8'h0C;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int OVERRIDE_BIT = 7;
  localparam int MASK_NOLOAD_BIT = 3;
  localparam int STAT_SHORT_BIT = 7;
  localparam int STAT_CODE_LSB = 4;
  localparam int STAT_OPEN_BIT = 3;
  localparam int EOC_NOLOAD_BIT = 6;
  localparam int EOC_CTRL_BIT = 3;
  localparam int EOC_FAULT_BIT = 2;
  localparam int EOC_EN1_BIT = 1;
  localparam int EOC_ADP_BIT = 0;
  localparam int INT_STOP = 0;
  localparam int INT_SHORT = 1;
  localparam int INT_OVP = 2;
  localparam int INT_ADAPTER_ON = 3;
  localparam int INT_NOLOAD = 4;
  localparam int INT_W = 5;
  // ---------------------------------------------------------------
  // end power transfer codes
  // ---------------------------------------------------------------
  localparam logic [7:0] EPT_ADAPTER = 8'h00;
  localparam logic [7:0] EPT_CHARGE_DONE = 8'h01;
  localparam logic [7:0] EPT_INT_FAULT = 8'h02;
  localparam logic [7:0] EPT_OVER_TEMP = 8'h03;
  // ---------------------------------------------------------------
  // strap measurement, converter counts rise with resistance
  // ---------------------------------------------------------------
  localparam int ADC_W = 10;
  typedef logic [ADC_W-1:0] adc_t;
  localparam adc_t STRAP_SHORT_MAX = 10'h010;
  localparam adc_t STRAP_OPEN_MIN = 10'h3C0;
  localparam adc_t STRAP_RANGE_MIN = 10'h050;
  localparam adc_t BAND_MAX [8] = '{10'h1F0, 10'h150, 10'h110,
    10'h0E0, 10'h0C0, 10'h0A0, 10'h084, 10'h06C};
  localparam logic [5:0] LIMIT_FIELD [8] = '{6'h05, 6'h09, 6'h0D,
    6'h0F, 6'h11, 6'h13, 6'h15, 6'h19};
  typedef enum logic [3:0] {
    SRC_IDLE = 4'h1,
    SRC_WIRELESS = 4'h2,
    SRC_DRAIN = 4'h4,
    SRC_ADAPTER = 4'h8
  } src_state_t;
endpackage

// ===== inc/limit_if.sv
// strap measurement carrier between control and decoder
`timescale 1ns/1ps
interface limit_if;
  charge_pkg::adc_t adcValue;
  logic adcValid;
  logic shortDet;
  logic openDet;
  logic [2:0] statusCode;
  logic [5:0] limitField;
  modport decoder(input adcValue, input adcValid, output shortDet,
    output openDet, output statusCode, output limitField);
  modport user(output adcValue, output adcValid, input shortDet,
    input openDet, input statusCode, input limitField);
endinterface

// ===== core/strap_limit_decode.sv
// maps one strap converter reading to short, open and limit codes
`timescale 1ns/1ps
module strap_limit_decode (
  input wire logic clk,
  input wire logic sys_rst,
  limit_if.decoder lk
);
  logic [2:0] bandCode;
  logic inRange;

  always_comb begin
    bandCode = 3'h0;
    inRange = (lk.adcValue >= charge_pkg::STRAP_RANGE_MIN) &&
      (lk.adcValue <= charge_pkg::BAND_MAX[0]);
    // bounds fall with code, so the last hit is the tightest band
    for (int i = 0; i < 8; i++) begin
      if (lk.adcValue <= charge_pkg::BAND_MAX[i]) begin
        bandCode = 3'(i); // R16
      end
    end
    if (!inRange) begin
      bandCode = 3'h0; // R15
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lk.shortDet <= 1'b0;
      lk.openDet <= 1'b0;
      lk.statusCode <= 3'h0;
      lk.limitField <= charge_pkg::LIMIT_FIELD[0];
    end else if (lk.adcValid) begin
      lk.shortDet <= lk.adcValue <= charge_pkg::STRAP_SHORT_MAX; // R11
      lk.openDet <= lk.adcValue >= charge_pkg::STRAP_OPEN_MIN; // R12
      lk.statusCode <= bandCode;
      lk.limitField <= charge_pkg::LIMIT_FIELD[bandCode]; // R14
    end
  end
endmodule

// ===== core/charge_source_control.sv
// charging source selection, stop messaging and current limit control
//
// Functional notes
// R1 - no-load mask bit suppresses end-of-charge, resets 0x0C
// R2 - both enable pins read low after reset
// R3 - wireless disable sends charge-complete stop message
// R4 - temperature fault stops wireless with stop message
// R5 - both low: adapter wins, wireless stops
// R6 - adapter control high: wireless wins, adapter stops
// R7 - wireless disabled alone: adapter still works
// R8 - both high: no source reaches output
// R9 - adapter gate closes only after output discharged
// R10 - adapter overvoltage opens adapter path at once
// R11 - shorted strap flags error, sends internal fault
// R12 - open strap A flags and uses register limit
// R13 - override bit makes register limit win
// R14 - limit field 50 mA steps, resets 1100 mA
// R15 - strap limit code, zero when out of range
// R16 - strap resistance maps to 500..1500 mA
// R17 - strap values come from internal 10-bit converter
// R18 - no-load still detected while message masked
`timescale 1ns/1ps
module charge_source_control (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wirelessDisablePin,
  input wire logic adapterControlPin,
  input wire logic tempFaultPin,
  input wire logic adapterSenseInput,
  input wire logic adapterOverVoltage,
  input wire logic outputDischarged,
  input wire logic wirelessActive,
  input wire logic qiMode,
  input wire logic noLoadDetect,
  input wire logic [1:0][charge_pkg::ADC_W-1:0] strapAdc,
  input wire logic strapAdcValid,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  output logic adapterSwitchGate,
  output logic wirelessEnable,
  output logic outputEnable,
  output logic endPowerSend,
  output logic [7:0] endPowerCode,
  output logic endChargeSend,
  output logic [7:0] endChargeCause,
  output logic [5:0] currentLimitLevel,
  output logic irq
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [5:0] syncStage1_reg;
  logic [5:0] syncStage2_reg;
  logic wdis, actl, tempF, adSense, ovp, outLow;

  // reset to zero so both enables read low until sampled
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      syncStage1_reg <= 6'h00; // R2
      syncStage2_reg <= 6'h00; // R2
    end else begin
      syncStage1_reg <= {adapterOverVoltage, adapterSenseInput,
        outputDischarged, tempFaultPin, adapterControlPin,
        wirelessDisablePin};
      syncStage2_reg <= syncStage1_reg;
    end
  end

  assign wdis = syncStage2_reg[0];
  assign actl = syncStage2_reg[1];
  assign tempF = syncStage2_reg[2];
  assign outLow = syncStage2_reg[3];
  assign adSense = syncStage2_reg[4];
  assign ovp = syncStage2_reg[5];

  // ---------------------------------------------------------------
  // strap decoders, one per strap pin
  // ---------------------------------------------------------------
  logic [1:0] strapShortVec;
  logic strapShort, strapOpenA;
  logic [2:0] strapCodeA;
  logic [5:0] strapFieldA;

  for (genvar i = 0; i < 2; i++) begin : strap
    limit_if lk ();
    assign lk.adcValue = strapAdc[i]; // R17
    assign lk.adcValid = strapAdcValid;
    assign strapShortVec[i] = lk.shortDet;
    strap_limit_decode dec (
      .clk(clk),
      .sys_rst(sys_rst),
      .lk(lk.decoder)
    );
  end

  assign strapShort = |strapShortVec; // R11
  assign strapOpenA = strap[0].lk.openDet;
  assign strapCodeA = strap[0].lk.statusCode;
  assign strapFieldA = strap[0].lk.limitField;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] limitCfg_reg;
  logic [3:0] eocMask_reg;
  logic [charge_pkg::INT_W-1:0] intStatus_reg;
  logic [charge_pkg::INT_W-1:0] intEnable_reg;
  logic [charge_pkg::INT_W-1:0] intEvent;
  logic [7:0] limitStat;
  logic wrCfg, wrMask, wrClr, wrEn;

  assign wrCfg = regWrEn && regAddr == charge_pkg::ADDR_LIMIT_CFG;
  assign wrMask = regWrEn && regAddr == charge_pkg::ADDR_EOC_MASK;
  assign wrClr = regWrEn && regAddr == charge_pkg::ADDR_INT_CLR;
  assign wrEn = regWrEn && regAddr == charge_pkg::ADDR_INT_EN;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      limitCfg_reg <= charge_pkg::RST_LIMIT_CFG; // R14
    end else if (wrCfg) begin
      // bit 6 is reserved and stays zero
      limitCfg_reg <= {regWrData[7], 1'b0, regWrData[5:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eocMask_reg <= charge_pkg::RST_EOC_MASK[3:0]; // R1
    end else if (wrMask) begin
      eocMask_reg <= regWrData[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      intEnable_reg <= '0;
    end else if (wrEn) begin
      intEnable_reg <= regWrData[charge_pkg::INT_W-1:0];
    end
  end

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      intStatus_reg <= '0;
    end else begin
      intStatus_reg <= (intStatus_reg &
        ~(wrClr ? regWrData[charge_pkg::INT_W-1:0] : '0)) | intEvent;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(intStatus_reg & intEnable_reg);
    end
  end

  assign limitStat = {strapShort, strapCodeA, strapOpenA, 3'h0}; // R15

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      case (regAddr)
        charge_pkg::ADDR_LIMIT_CFG: regRdData <= limitCfg_reg;
        charge_pkg::ADDR_LIMIT_STAT: regRdData <= limitStat;
        charge_pkg::ADDR_EOC_MASK: regRdData <= {4'h0, eocMask_reg};
        charge_pkg::ADDR_INT_STAT: regRdData <= 8'(intStatus_reg);
        charge_pkg::ADDR_INT_EN: regRdData <= 8'(intEnable_reg);
        default: regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // current limit selection
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      currentLimitLevel <= charge_pkg::RST_LIMIT_CFG[5:0];
    end else if (limitCfg_reg[charge_pkg::OVERRIDE_BIT] ||
      strapOpenA) begin
      currentLimitLevel <= limitCfg_reg[5:0]; // R12 R13
    end else begin
      currentLimitLevel <= strapFieldA; // R13
    end
  end

  // ---------------------------------------------------------------
  // source arbitration
  // ---------------------------------------------------------------
  charge_pkg::src_state_t srcState_reg, srcNext;
  logic adapterReady, wirelessAllowed, adapterAllowed;
  logic noLoadEoc, stopNow;

  assign adapterReady = adSense && !ovp; // R10
  // low adapter control means adapter priority
  assign wirelessAllowed = !wdis && !tempF && !strapShort && // R3 R4
    !(!actl && adapterReady); // R5 R8
  assign adapterAllowed = adapterReady && !(wdis && actl) && // R7 R8
    !(actl && wirelessActive && wirelessAllowed); // R6
  assign noLoadEoc = noLoadDetect && !qiMode &&
    !eocMask_reg[charge_pkg::MASK_NOLOAD_BIT]; // R1
  assign stopNow = srcState_reg == charge_pkg::SRC_WIRELESS &&
    wirelessActive && (!wirelessAllowed || noLoadEoc);

  always_comb begin
    srcNext = srcState_reg;
    case (srcState_reg)
      charge_pkg::SRC_IDLE: begin
        if (adapterAllowed) begin
          srcNext = charge_pkg::SRC_DRAIN;
        end else if (wirelessActive && wirelessAllowed) begin
          srcNext = charge_pkg::SRC_WIRELESS;
        end
      end
      charge_pkg::SRC_WIRELESS: begin
        if (stopNow || !wirelessActive) begin
          srcNext = adapterAllowed ? charge_pkg::SRC_DRAIN
            : charge_pkg::SRC_IDLE; // R5
        end
      end
      charge_pkg::SRC_DRAIN: begin
        if (!adapterAllowed) begin
          srcNext = charge_pkg::SRC_IDLE;
        end else if (outLow) begin
          srcNext = charge_pkg::SRC_ADAPTER; // R9
        end
      end
      charge_pkg::SRC_ADAPTER: begin
        if (!adapterAllowed) begin
          srcNext = charge_pkg::SRC_IDLE; // R6 R10
        end
      end
      default: srcNext = charge_pkg::SRC_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      srcState_reg <= charge_pkg::SRC_IDLE;
    end else begin
      srcState_reg <= srcNext;
    end
  end

  // gate is active low: low closes the adapter switch
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      adapterSwitchGate <= 1'b1;
      outputEnable <= 1'b0;
      wirelessEnable <= 1'b0;
    end else begin
      adapterSwitchGate <= srcNext != charge_pkg::SRC_ADAPTER; // R9
      outputEnable <= srcNext == charge_pkg::SRC_WIRELESS; // R8
      wirelessEnable <= wirelessAllowed && // R7
        (srcNext == charge_pkg::SRC_IDLE ||
        srcNext == charge_pkg::SRC_WIRELESS);
    end
  end

  // ---------------------------------------------------------------
  // stop messages
  // ---------------------------------------------------------------
  // message goes out in the same edge the output is switched off
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      endPowerSend <= 1'b0;
      endPowerCode <= charge_pkg::EPT_ADAPTER;
    end else begin
      endPowerSend <= stopNow && qiMode;
      if (stopNow && qiMode) begin
        if (tempF) begin
          endPowerCode <= charge_pkg::EPT_OVER_TEMP; // R4
        end else if (strapShort) begin
          endPowerCode <= charge_pkg::EPT_INT_FAULT; // R11
        end else if (wdis) begin
          endPowerCode <= charge_pkg::EPT_CHARGE_DONE; // R3
        end else begin
          endPowerCode <= charge_pkg::EPT_ADAPTER; // R5
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      endChargeSend <= 1'b0;
      endChargeCause <= 8'h00;
    end else begin
      endChargeSend <= stopNow && !qiMode; // R3 R4
      if (stopNow && !qiMode) begin
        endChargeCause <= 8'h00;
        endChargeCause[charge_pkg::EOC_CTRL_BIT] <= tempF;
        endChargeCause[charge_pkg::EOC_FAULT_BIT] <= strapShort;
        endChargeCause[charge_pkg::EOC_EN1_BIT] <= wdis;
        endChargeCause[charge_pkg::EOC_ADP_BIT] <= adapterReady;
        endChargeCause[charge_pkg::EOC_NOLOAD_BIT] <= noLoadEoc;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt events
  // ---------------------------------------------------------------
  logic shortSeen_reg, ovpSeen_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shortSeen_reg <= 1'b0;
      ovpSeen_reg <= 1'b0;
    end else begin
      shortSeen_reg <= strapShort;
      ovpSeen_reg <= ovp;
    end
  end

  always_comb begin
    intEvent = '0;
    intEvent[charge_pkg::INT_STOP] = stopNow;
    intEvent[charge_pkg::INT_SHORT] = strapShort && !shortSeen_reg;
    intEvent[charge_pkg::INT_OVP] = ovp && !ovpSeen_reg;
    intEvent[charge_pkg::INT_ADAPTER_ON] =
      srcNext == charge_pkg::SRC_ADAPTER &&
      srcState_reg != charge_pkg::SRC_ADAPTER;
    // logged even while the message itself is masked
    intEvent[charge_pkg::INT_NOLOAD] = noLoadDetect; // R18
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  mask_suppresses_a: assert property ( // R1
    (noLoadDetect && eocMask_reg[charge_pkg::MASK_NOLOAD_BIT] &&
    wirelessAllowed) |=> !endChargeSend)
    else $error("masked no-load produced an end-of-charge");

  pins_low_reset_a: assert property ( // R2
    $past(sys_rst) |-> syncStage2_reg == 6'h00)
    else $error("pins not treated low after reset");

  disable_stop_a: assert property ( // R3
    (srcState_reg == charge_pkg::SRC_WIRELESS && wirelessActive &&
    wdis && !tempF && !strapShort && qiMode) |=>
    endPowerSend && endPowerCode == charge_pkg::EPT_CHARGE_DONE)
    else $error("wireless disable gave no charge-complete");

  temp_fault_stop_a: assert property ( // R4
    (srcState_reg == charge_pkg::SRC_WIRELESS && wirelessActive &&
    tempF) |=> (endPowerSend || endChargeSend) && !outputEnable)
    else $error("temperature fault did not stop wireless");

  adapter_priority_a: assert property ( // R5
    (srcState_reg == charge_pkg::SRC_WIRELESS && !wdis && !actl &&
    adapterReady) |=> srcState_reg == charge_pkg::SRC_DRAIN)
    else $error("adapter priority not honoured");

  wireless_priority_a: assert property ( // R6
    (srcState_reg == charge_pkg::SRC_ADAPTER && actl &&
    wirelessActive && wirelessAllowed) |=> adapterSwitchGate)
    else $error("adapter kept while wireless has priority");

  both_disabled_a: assert property ( // R8
    (wdis && actl) |=> adapterSwitchGate && !wirelessEnable &&
    !outputEnable)
    else $error("power delivered with both sources disabled");

  gate_after_drain_a: assert property ( // R9
    $fell(adapterSwitchGate) |-> $past(outLow) && !outputEnable)
    else $error("adapter gate closed before output discharged");

  overvoltage_open_a: assert property ( // R10
    ovp |=> adapterSwitchGate)
    else $error("adapter path not opened on overvoltage");

  override_limit_a: assert property ( // R13
    limitCfg_reg[charge_pkg::OVERRIDE_BIT] |=>
    currentLimitLevel == $past(limitCfg_reg[5:0]))
    else $error("register limit not applied under override");

  short_fault_a: assert property ( // R11
    (stopNow && qiMode && strapShort && !tempF) |=>
    endPowerCode == charge_pkg::EPT_INT_FAULT)
    else $error("strap short did not send internal fault");

  stop_cover: cover property (endPowerSend ##1 !outputEnable);
  takeover_cover: cover property (
    srcState_reg == charge_pkg::SRC_WIRELESS ##[1:20]
    srcState_reg == charge_pkg::SRC_ADAPTER);
  masked_cover: cover property (
    noLoadDetect && eocMask_reg[charge_pkg::MASK_NOLOAD_BIT]);
  irq_cover: cover property ($rose(irq));
endmodule

// ===== verification/adapter_supply_model.sv
// wired adapter supply and output rail seen from the control block
`timescale 1ns/1ps
module adapter_supply_model (
  input wire logic clk,
  input wire logic plugged,
  input wire logic surge,
  input wire logic slow,
  input wire logic outputEnable,
  input wire logic adapterSwitchGate,
  output logic adapterSenseInput,
  output logic adapterOverVoltage,
  output logic outputDischarged
);
  int railCnt;
  // -------------------------------------------------------------
  // supply levels
  // -------------------------------------------------------------
  assign adapterSenseInput = plugged;
  assign adapterOverVoltage = plugged & surge;
  // rail bleeds down over some cycles, never at once
  always_ff @(posedge clk) begin
    if (outputEnable) begin
      railCnt <= slow ? 12 : 2;
    end else if (railCnt != 0) begin
      railCnt <= railCnt - 1;
    end
  end
  // a closed adapter switch holds the rail up again
  assign outputDischarged = (railCnt == 0) && adapterSwitchGate;
endmodule

// ===== verification/charge_source_control_test.sv
// self-checking bench for the charge source control block
`timescale 1ns/1ps
module charge_source_control_test;
  logic clk = 0, sys_rst = 1, plugged = 0, surge = 0, slow = 0;
  logic wirelessDisablePin = 0, adapterControlPin = 0, tempFaultPin = 0;
  logic wirelessActive = 0, qiMode = 1, noLoadDetect = 0;
  logic adapterSenseInput, adapterOverVoltage, outputDischarged;
  logic [1:0][charge_pkg::ADC_W-1:0] strapAdc = {2{10'h100}};
  logic strapAdcValid = 0, regWrEn = 0, regRdEn = 0;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, d;
  logic [7:0] endPowerCode, endChargeCause;
  logic adapterSwitchGate, wirelessEnable, outputEnable, irq;
  logic endPowerSend, endChargeSend;
  logic [5:0] currentLimitLevel, lv;
  charge_pkg::adc_t vals[$];
  int n_fail = 0, checked = 0, nEoc = 0, k, lo;

  charge_source_control charge_source_control_i (.clk, .sys_rst,
    .wirelessDisablePin, .adapterControlPin, .tempFaultPin,
    .adapterSenseInput, .adapterOverVoltage, .outputDischarged,
    .wirelessActive, .qiMode, .noLoadDetect, .strapAdc, .strapAdcValid,
    .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
    .adapterSwitchGate, .wirelessEnable, .outputEnable, .endPowerSend,
    .endPowerCode, .endChargeSend, .endChargeCause, .currentLimitLevel,
    .irq);
  adapter_supply_model adapter_supply_model_i (.clk, .plugged, .surge,
    .slow, .outputEnable, .adapterSwitchGate, .adapterSenseInput,
    .adapterOverVoltage, .outputDischarged);

  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (endChargeSend === 1'b1) nEoc <= nEoc + 1;
  // -------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rst(input logic dis, ctl, qi, act, plug);
    @(posedge clk);
    {wirelessDisablePin, adapterControlPin, qiMode} <= {dis, ctl, qi};
    {wirelessActive, plugged, surge, tempFaultPin} <= {act, plug, 2'b00};
    strapAdc <= {2{10'h100}};
    sys_rst <= 1;
    repeat (5) @(posedge clk);
    sys_rst <= 0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, v);
    @(posedge clk);
    {regAddr, regWrData, regWrEn} <= {a, v, 1'b1};
    @(posedge clk);
    regWrEn <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    {regAddr, regRdEn} <= {a, 1'b1};
    @(posedge clk);
    regRdEn <= 0;
    #1 d = regRdData;
  endtask
  task automatic nl;
    @(posedge clk);
    noLoadDetect <= 1;
    @(posedge clk);
    noLoadDetect <= 0;
    #1;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return endPowerSend;
      1: return endChargeSend;
      2: return !adapterSwitchGate;
      3: return irq;
      4: return adapterSwitchGate;
      default: return wirelessEnable;
    endcase
  endfunction
  // bounded wait; a run-out ends the run
  task automatic waitHi(input int s, lim);
    for (int i = 0; i < lim && pick(s) !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (pick(s) !== 1'b1) begin
      n_fail++;
      $display("mismatch wait %0d expected 1 seen 0", s);
      results();
    end
  endtask
  function automatic int band(input charge_pkg::adc_t v);
    if (v < charge_pkg::STRAP_RANGE_MIN || v > charge_pkg::BAND_MAX[0])
      return 0;
    for (int i = 7; i > 0; i--)
      if (v <= charge_pkg::BAND_MAX[i]) return i;
    return 0;
  endfunction
  function automatic logic [5:0] lvl(input int c);
    int ma [8] = '{500, 700, 900, 1000, 1100, 1200, 1300, 1500};
    return 6'(ma[c] / 50 - 5);
  endfunction
  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  initial begin
    void'($urandom(72917));
    rst(0, 0, 1, 0, 0);
    chk("gate", 8'h01, 8'(adapterSwitchGate));
    // no valid strap reading yet, so the strap path gives its lowest limit
    chk("level", 8'(charge_pkg::LIMIT_FIELD[0]), 8'(currentLimitLevel));
    rd(charge_pkg::ADDR_LIMIT_CFG);
    chk("cfg", charge_pkg::RST_LIMIT_CFG, d);
    rd(charge_pkg::ADDR_EOC_MASK);
    chk("mask", charge_pkg::RST_EOC_MASK, d);
    rd(charge_pkg::ADDR_LIMIT_STAT);
    chk("stat", 8'h00, d);
    rd(8'h55);
    chk("unmapped", 8'h00, d);
    lv = 6'($urandom_range(25, 5));
    wr(charge_pkg::ADDR_LIMIT_CFG, {2'b01, lv});
    wr(charge_pkg::ADDR_LIMIT_STAT, 8'hFF);
    rd(charge_pkg::ADDR_LIMIT_CFG);
    chk("cfg", {2'b00, lv}, d);
    rd(charge_pkg::ADDR_LIMIT_STAT);
    chk("stat ro", 8'h00, d);
    // strap bands, the top edge and both out-of-range sides
    for (int i = 0; i < 8; i++) begin
      lo = i == 7 ? 80 : int'(charge_pkg::BAND_MAX[i + 1]) + 1;
      vals.push_back(10'($urandom_range(charge_pkg::BAND_MAX[i], lo)));
    end
    vals.push_back(charge_pkg::BAND_MAX[0]);
    vals.push_back(10'h200);
    vals.push_back(10'h04F);
    strapAdcValid <= 1;
    foreach (vals[j]) begin
      @(posedge clk);
      strapAdc[0] <= vals[j];
      repeat (4) @(posedge clk);
      rd(charge_pkg::ADDR_LIMIT_STAT);
      chk("code", {1'b0, 3'(band(vals[j])), 4'h0}, d);
      chk("lim", {2'b00, lvl(band(vals[j]))}, 8'(currentLimitLevel));
    end
    wr(charge_pkg::ADDR_LIMIT_CFG, {2'b10, lv});
    repeat (3) @(posedge clk);
    #1 chk("override", {2'b00, lv}, 8'(currentLimitLevel));
    wr(charge_pkg::ADDR_LIMIT_CFG, {2'b00, lv});
    strapAdc[0] <= charge_pkg::STRAP_OPEN_MIN;
    repeat (4) @(posedge clk);
    rd(charge_pkg::ADDR_LIMIT_STAT);
    chk("open", 8'h08, d);
    chk("open lim", {2'b00, lv}, 8'(currentLimitLevel));
    // shorted strap during Qi transfer
    rst(0, 0, 1, 1, 0);
    waitHi(5, 10);
    strapAdc[1] <= 10'h008;
    waitHi(0, 8);
    chk("short ept", charge_pkg::EPT_INT_FAULT, endPowerCode);
    rd(charge_pkg::ADDR_LIMIT_STAT);
    chk("short", 8'h80, d & 8'h80);
    rd(charge_pkg::ADDR_INT_STAT);
    chk("int short", 8'h03, d);
    // disable pin and temperature fault in both modes
    for (k = 0; k < 4; k++) begin
      rst(0, 0, k[0], 1, 0);
      waitHi(5, 10);
      if (k < 2) wirelessDisablePin <= 1;
      else tempFaultPin <= 1;
      waitHi(k[0] ? 0 : 1, 8);
      if (k[0]) chk("ept", k < 2 ? 8'h01 : 8'h03, endPowerCode);
      else chk("eoc", k < 2 ? 8'h02 : 8'h08, endChargeCause);
      @(posedge clk);
      #1 chk("wl off", 8'h00, 8'(wirelessEnable));
    end
    // adapter arrives, both pins low, slow rail
    slow <= 1;
    rst(0, 0, 1, 1, 0);
    waitHi(5, 10);
    plugged <= 1;
    waitHi(0, 8);
    chk("adp ept", charge_pkg::EPT_ADAPTER, endPowerCode);
    repeat (5) @(posedge clk);
    #1 chk("out", 8'h00, 8'(outputEnable));
    chk("gate held", 8'h01, 8'(adapterSwitchGate));
    waitHi(2, 20);
    surge <= 1;
    waitHi(4, 6);
    // wireless priority
    rst(0, 1, 1, 1, 0);
    waitHi(5, 10);
    plugged <= 1;
    repeat (10) @(posedge clk);
    #1 chk("lh gate", 8'h01, 8'(adapterSwitchGate));
    chk("lh wl", 8'h01, 8'(wirelessEnable));
    // adapter already closed, then wireless starts and takes over
    rst(0, 1, 1, 0, 1);
    waitHi(2, 20);
    rd(charge_pkg::ADDR_INT_STAT);
    chk("int adp", 8'h08, d);
    wirelessActive <= 1;
    waitHi(4, 6);
    rst(1, 0, 1, 1, 1);
    waitHi(2, 20);
    chk("hl wl", 8'h00, 8'(wirelessEnable));
    rst(1, 1, 1, 1, 1);
    repeat (20) @(posedge clk);
    #1;
    chk("hh", 8'h01, {wirelessEnable, outputEnable, adapterSwitchGate});
    // no-load in PMA: masked, interrupt, cleared, unmasked
    rst(0, 0, 0, 1, 0);
    waitHi(5, 10);
    wr(charge_pkg::ADDR_EOC_MASK, 8'h08);
    wr(charge_pkg::ADDR_INT_EN, 8'h10);
    k = nEoc;
    nl();
    waitHi(3, 5);
    chk("masked", 8'(k), 8'(nEoc));
    rd(charge_pkg::ADDR_INT_STAT);
    chk("int", 8'h10, d);
    wr(charge_pkg::ADDR_INT_CLR, 8'h10);
    wr(charge_pkg::ADDR_INT_EN, 8'h00);
    rd(charge_pkg::ADDR_INT_STAT);
    chk("int clr", 8'h00, d);
    nl();
    rd(charge_pkg::ADDR_INT_STAT);
    chk("int", 8'h10, d);
    chk("irq masked", 8'h00, 8'(irq));
    wr(charge_pkg::ADDR_EOC_MASK, 8'h00);
    nl();
    waitHi(1, 6);
    chk("noload", 8'h40, endChargeCause);
    results();
  end
endmodule
